// ==== shared/hpc_pkg.sv ====
`default_nettype none

package hpc_pkg;

	// ----------------------------------------------------------------
	// system clock and clock output rates
	// ----------------------------------------------------------------
	localparam int SYS_CLK_KHZ = 100000;
	localparam int AUX_CLOCK_OUTPUT_F0_KHZ = 1978;
	localparam int AUX_CLOCK_OUTPUT_F1_KHZ = 3955;
	localparam int AUX_CLOCK_OUTPUT_F2_KHZ = 7910;
	localparam int AUX_CLOCK_OUTPUT_F3_KHZ = 15820;
	// half periods in system cycles, rounded down
	localparam logic [4:0] AUX_CLOCK_OUTPUT_HALF_0 = 5'(SYS_CLK_KHZ / (2 * AUX_CLOCK_OUTPUT_F0_KHZ));
	localparam logic [4:0] AUX_CLOCK_OUTPUT_HALF_1 = 5'(SYS_CLK_KHZ / (2 * AUX_CLOCK_OUTPUT_F1_KHZ));
	localparam logic [4:0] AUX_CLOCK_OUTPUT_HALF_2 = 5'(SYS_CLK_KHZ / (2 * AUX_CLOCK_OUTPUT_F2_KHZ));
	localparam logic [4:0] AUX_CLOCK_OUTPUT_HALF_3 = 5'(SYS_CLK_KHZ / (2 * AUX_CLOCK_OUTPUT_F3_KHZ));

	// ----------------------------------------------------------------
	// clock configuration register layout
	// ----------------------------------------------------------------
	localparam int         CFG_RATE_LSB    = 0;
	localparam int         CFG_DISABLE_BIT = 5;
	localparam int         CFG_STANDBY_LSB = 6;
	localparam logic [7:0] CFG_RESET       = 8'h00;

	// ----------------------------------------------------------------
	// two-wire addresses (7-bit) and interface codes
	// ----------------------------------------------------------------
	localparam logic [6:0] TWI_ADDR_LO = 7'h28;
	localparam logic [6:0] TWI_ADDR_HI = 7'h6A;
	localparam logic       INTF_TWI    = 1'b0;
	localparam logic       INTF_SPI    = 1'b1;

	// ----------------------------------------------------------------
	// pin synchroniser slots and their idle values
	// ----------------------------------------------------------------
	localparam int         SYN_RSTN = 0;
	localparam int         SYN_INTERFACE_SELECT_STRAP = 1;
	localparam int         SYN_ADDR = 2;
	localparam int         SYN_SCL  = 3;
	localparam int         SYN_SDA  = 4;
	localparam int         SYN_SPIT = 5;
	localparam int         SYN_N    = 6;
	localparam logic [5:0] SYN_INIT = 6'h19;

	typedef enum logic [6:0] {
		TWI_IDLE  = 7'b0000001,
		TWI_ADDR  = 7'b0000010,
		TWI_ACK_A = 7'b0000100,
		TWI_WRITE = 7'b0001000,
		TWI_ACK_W = 7'b0010000,
		TWI_READ  = 7'b0100000,
		TWI_RACK  = 7'b1000000
	} hpc_twi_state_e;

endpackage

`default_nettype wire

// ==== logic/hpc_clkout_div.sv ====
`timescale 1ns/100ps
`default_nettype none

module hpc_clkout_div
	import hpc_pkg::*;
(
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// configuration
	input  wire logic [1:0] rate_sel_i,
	input  wire logic       disable_i,
	// pin
	output logic            aux_clock_output_o,
	output logic            aux_clock_output_oe_o
);

	logic [4:0] half_d;
	logic [4:0] cnt_q;
	logic       wrap;

	always_comb begin
		unique case (rate_sel_i)
			2'b00: half_d = AUX_CLOCK_OUTPUT_HALF_0;
			2'b01: half_d = AUX_CLOCK_OUTPUT_HALF_1;
			2'b10: half_d = AUX_CLOCK_OUTPUT_HALF_2;
			2'b11: half_d = AUX_CLOCK_OUTPUT_HALF_3;
		endcase
	end

	assign wrap = (cnt_q >= half_d - 5'h01);

	always_ff @(posedge clk_i) begin
		if (rst_i || wrap) begin
			cnt_q <= 5'h00;
		end else begin
			cnt_q <= cnt_q + 5'h01;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			aux_clock_output_o <= 1'b0;
		end else if (wrap) begin
			aux_clock_output_o <= ~aux_clock_output_o;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			aux_clock_output_oe_o <= 1'b1;
		end else begin
			aux_clock_output_oe_o <= ~disable_i;
		end
	end

endmodule

`default_nettype wire

// ==== logic/hpc_host_port.sv ====
// Function
// - strap low two-wire, high SPI mode 0
// - address strap picks 50/51 or D4/D5
// - no answer to any other address
// - rate field picks four clock output rates
// - slowest clock output rate after reset
// - disable bit stops driving clock output
// - status high while a read byte waits
// - commands ignored while status is high
// - low reset pin resets the device
// - data-in pin: SPI input, two-wire open-drain
// - data-out pin driven only in SPI mode
// - select pin used only in SPI mode
// - rate and disable in clock config register
`timescale 1ns/100ps
`default_nettype none

module hpc_host_port
	import hpc_pkg::*;
(
	// clocks and reset
	input  wire logic       clk_i,
	input  wire logic       sys_rst_i,
	input  wire logic       host_sck_i,
	// straps and reset pin
	input  wire logic       device_reset_n_i,
	input  wire logic       interface_select_strap_i,
	input  wire logic       address_strap_i,
	// serial pins
	input  wire logic       spi_select_n_i,
	input  wire logic       host_data_in_io_i,
	output logic            host_data_in_io_o,
	output logic            host_data_in_io_oe_o,
	output logic            spi_data_out_pin_o,
	output logic            spi_data_out_pin_oe_o,
	output logic            host_status_o,
	output logic            aux_clock_output_o,
	output logic            aux_clock_output_oe_o,
	// clock configuration
	input  wire logic       clk_cfg_wr_i,
	input  wire logic [7:0] clk_cfg_data_i,
	output logic      [7:0] clk_cfg_o,
	output logic            spi_mode_o,
	// core side
	input  wire logic [7:0] resp_data_i,
	input  wire logic       resp_valid_i,
	output logic            resp_ready_o,
	output logic      [7:0] cmd_data_o,
	output logic            cmd_valid_o
);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [SYN_N-1:0] raw;
	logic [SYN_N-1:0] s1_q;
	logic [SYN_N-1:0] s2_q;
	logic [SYN_N-1:0] s3_q;
	logic [SYN_N-1:0] stable_q;
	logic             spi_t_q;
	logic             dev_rst;

	assign raw = {spi_t_q, host_data_in_io_i, host_sck_i, address_strap_i,
		interface_select_strap_i, device_reset_n_i};

	for (genvar i = 0; i < SYN_N; i++) begin : g_sync
		always_ff @(posedge clk_i) begin
			s1_q[i] <= raw[i];
			s2_q[i] <= s1_q[i];
			s3_q[i] <= s2_q[i];
		end
		always_ff @(posedge clk_i) begin
			if (s2_q[i] == s3_q[i]) begin
				stable_q[i] <= s3_q[i];
			end else if (sys_rst_i) begin
				stable_q[i] <= SYN_INIT[i];
			end
		end
	end

	assign dev_rst = sys_rst_i | ~stable_q[SYN_RSTN];

	// ----------------------------------------------------------------
	// straps
	// ----------------------------------------------------------------
	logic strap_taken_q;
	logic spi_mode_q;
	logic addr_hi_q;
	logic spi_on;
	logic twi_on;

	always_ff @(posedge clk_i) begin
		if (dev_rst) begin
			strap_taken_q <= 1'b0;
			spi_mode_q    <= INTF_TWI;
			addr_hi_q     <= 1'b0;
		end else if (!strap_taken_q) begin
			strap_taken_q <= 1'b1;
			spi_mode_q    <= stable_q[SYN_INTERFACE_SELECT_STRAP];
			addr_hi_q     <= stable_q[SYN_ADDR];
		end
	end

	assign spi_on     = strap_taken_q & (spi_mode_q == INTF_SPI);
	assign twi_on     = strap_taken_q & (spi_mode_q == INTF_TWI);
	assign spi_mode_o = spi_mode_q;

	// ----------------------------------------------------------------
	// clock configuration and clock output
	// ----------------------------------------------------------------
	logic [7:0] clk_cfg_q;

	always_ff @(posedge clk_i) begin
		if (dev_rst) begin
			clk_cfg_q <= CFG_RESET;
		end else if (clk_cfg_wr_i) begin
			clk_cfg_q <= clk_cfg_data_i;
		end
	end

	assign clk_cfg_o = clk_cfg_q;

	hpc_clkout_div u_div (
		.clk_i                 (clk_i),
		.rst_i                 (dev_rst),
		.rate_sel_i            (clk_cfg_q[CFG_RATE_LSB +: 2]),
		.disable_i             (clk_cfg_q[CFG_DISABLE_BIT]),
		.aux_clock_output_o    (aux_clock_output_o),
		.aux_clock_output_oe_o (aux_clock_output_oe_o)
	);

	// ----------------------------------------------------------------
	// SPI link, on the host serial clock
	// ----------------------------------------------------------------
	logic [2:0] spi_cnt_q;
	logic [7:0] spi_sh_q;
	logic [7:0] spi_rx_q;
	logic       spi_out_q;
	logic       spi_first_q;
	logic [7:0] tx_data_q;

	// shift in on rising edge, framed by select
	always_ff @(posedge host_sck_i or posedge spi_select_n_i) begin
		if (spi_select_n_i) begin
			spi_cnt_q <= 3'h0;
			spi_sh_q  <= 8'h00;
		end else begin
			spi_cnt_q <= spi_cnt_q + 3'h1;
			spi_sh_q  <= {spi_sh_q[6:0], host_data_in_io_i};
		end
	end

	// completed byte held for the system side, event as toggle
	always_ff @(posedge host_sck_i or negedge device_reset_n_i) begin
		if (!device_reset_n_i) begin
			spi_rx_q <= 8'h00;
			spi_t_q  <= 1'b0;
		end else if (!spi_select_n_i && spi_cnt_q == 3'h7) begin
			spi_rx_q <= {spi_sh_q[6:0], host_data_in_io_i};
			spi_t_q  <= ~spi_t_q;
		end
	end

	// tx_data_q stays fixed while status is high, so it is read directly
	always_ff @(negedge host_sck_i or posedge spi_select_n_i) begin
		if (spi_select_n_i) begin
			spi_out_q   <= 1'b0;
			spi_first_q <= 1'b1;
		end else begin
			spi_out_q   <= tx_data_q[3'h7 - spi_cnt_q];
			spi_first_q <= 1'b0;
		end
	end

	assign spi_data_out_pin_o    = spi_first_q ? tx_data_q[7] : spi_out_q;
	assign spi_data_out_pin_oe_o = spi_on & ~spi_select_n_i;

	logic spi_seen_q;
	logic spi_evt;

	always_ff @(posedge clk_i) begin
		if (dev_rst) begin
			spi_seen_q <= stable_q[SYN_SPIT];
		end else begin
			spi_seen_q <= stable_q[SYN_SPIT];
		end
	end

	assign spi_evt = spi_on & (stable_q[SYN_SPIT] != spi_seen_q);

	// ----------------------------------------------------------------
	// two-wire slave, oversampled on the system clock
	// ----------------------------------------------------------------
	hpc_twi_state_e twi_st_q;
	logic [3:0]     twi_cnt_q;
	logic [7:0]     twi_sh_q;
	logic           twi_rw_q;
	logic           twi_drv_q;
	logic           scl_p_q;
	logic           sda_p_q;
	logic           scl;
	logic           sda;
	logic           rise;
	logic           fall;
	logic           start;
	logic           stop;
	logic [6:0]     my_addr;
	logic           twi_wr_evt;
	logic           twi_pop;

	assign scl     = stable_q[SYN_SCL];
	assign sda     = stable_q[SYN_SDA];
	assign rise    = scl & ~scl_p_q;
	assign fall    = ~scl & scl_p_q;
	assign start   = scl & scl_p_q & sda_p_q & ~sda;
	assign stop    = scl & scl_p_q & ~sda_p_q & sda;
	assign my_addr = addr_hi_q ? TWI_ADDR_HI : TWI_ADDR_LO;

	always_ff @(posedge clk_i) begin
		if (dev_rst) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_p_q <= scl;
			sda_p_q <= sda;
		end
	end

	assign twi_wr_evt = (twi_st_q == TWI_WRITE) & fall & (twi_cnt_q == 4'h8);
	assign twi_pop    = (twi_st_q == TWI_READ) & fall & (twi_cnt_q == 4'h8);

	always_ff @(posedge clk_i) begin
		if (dev_rst || !twi_on) begin
			twi_st_q  <= TWI_IDLE;
			twi_cnt_q <= 4'h0;
			twi_sh_q  <= 8'h00;
			twi_rw_q  <= 1'b0;
			twi_drv_q <= 1'b0;
		end else if (start) begin
			twi_st_q  <= TWI_ADDR;
			twi_cnt_q <= 4'h0;
			twi_drv_q <= 1'b0;
		end else if (stop) begin
			twi_st_q  <= TWI_IDLE;
			twi_drv_q <= 1'b0;
		end else begin
			unique case (twi_st_q)
				TWI_IDLE: begin
				end
				TWI_ADDR, TWI_WRITE: begin
					if (rise) begin
						twi_sh_q  <= {twi_sh_q[6:0], sda};
						twi_cnt_q <= twi_cnt_q + 4'h1;
					end else if (fall && twi_cnt_q == 4'h8) begin
						if (twi_st_q == TWI_WRITE) begin
							twi_drv_q <= 1'b1;
							twi_st_q  <= TWI_ACK_W;
						end else if (twi_sh_q[7:1] == my_addr) begin
							twi_drv_q <= 1'b1;
							twi_rw_q  <= twi_sh_q[0];
							twi_st_q  <= TWI_ACK_A;
						end else begin
							twi_st_q  <= TWI_IDLE;
						end
					end
				end
				TWI_ACK_A, TWI_RACK: begin
					if (rise && twi_st_q == TWI_RACK && sda) begin
						twi_st_q <= TWI_IDLE;
					end else if (fall) begin
						twi_cnt_q <= 4'h0;
						if (twi_rw_q) begin
							twi_drv_q <= ~tx_data_q[7];
							twi_sh_q  <= {tx_data_q[6:0], 1'b0};
							twi_st_q  <= TWI_READ;
						end else begin
							twi_drv_q <= 1'b0;
							twi_st_q  <= TWI_WRITE;
						end
					end
				end
				TWI_ACK_W: begin
					if (fall) begin
						twi_drv_q <= 1'b0;
						twi_cnt_q <= 4'h0;
						twi_st_q  <= TWI_WRITE;
					end
				end
				TWI_READ: begin
					if (rise) begin
						twi_cnt_q <= twi_cnt_q + 4'h1;
					end else if (fall && twi_cnt_q == 4'h8) begin
						twi_drv_q <= 1'b0;
						twi_st_q  <= TWI_RACK;
					end else if (fall) begin
						twi_drv_q <= ~twi_sh_q[7];
						twi_sh_q  <= {twi_sh_q[6:0], 1'b0};
					end
				end
			endcase
		end
	end

	assign host_data_in_io_o    = 1'b0;
	assign host_data_in_io_oe_o = twi_on & twi_drv_q;

	// ----------------------------------------------------------------
	// response byte and handshake status
	// ----------------------------------------------------------------
	logic status_q;
	logic pop;
	logic rx_evt;

	assign pop          = status_q & (spi_evt | twi_pop);
	assign rx_evt       = spi_evt | twi_wr_evt;
	assign resp_ready_o = ~status_q;

	always_ff @(posedge clk_i) begin
		if (dev_rst) begin
			status_q <= 1'b0;
		end else if (pop) begin
			status_q <= 1'b0;
		end else if (resp_valid_i) begin
			status_q <= 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (dev_rst) begin
			tx_data_q <= 8'hFF;
		end else if (resp_valid_i && !status_q) begin
			tx_data_q <= resp_data_i;
		end
	end

	assign host_status_o = status_q;

	always_ff @(posedge clk_i) begin
		if (dev_rst) begin
			cmd_valid_o <= 1'b0;
			cmd_data_o  <= 8'h00;
		end else begin
			cmd_valid_o <= rx_evt & ~status_q;
			if (rx_evt && !status_q) begin
				cmd_data_o <= spi_on ? spi_rx_q : twi_sh_q;
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (dev_rst);

	chk_status_load: assert property (
		(resp_valid_i && !status_q) |=> (host_status_o && tx_data_q == $past(resp_data_i)))
		else $error("status not raised after response byte");
	chk_cmd_ignored: assert property (
		cmd_valid_o |-> $past(!status_q))
		else $error("command accepted while status high");
	chk_rate_reset: assert property (disable iff (1'b0)
		$fell(dev_rst) |-> (clk_cfg_q[CFG_RATE_LSB +: 2] == 2'b00 && aux_clock_output_oe_o))
		else $error("clock output not at slowest rate after reset");
	chk_clkout_off: assert property (
		clk_cfg_q[CFG_DISABLE_BIT] |=> !aux_clock_output_oe_o)
		else $error("clock output still driven when disabled");
	chk_strap_take: assert property (
		$rose(strap_taken_q) |-> (spi_mode_q == $past(stable_q[SYN_INTERFACE_SELECT_STRAP])
			&& addr_hi_q == $past(stable_q[SYN_ADDR])))
		else $error("straps not captured at reset release");
	chk_strap_hold: assert property (
		$past(strap_taken_q) |-> $stable(spi_mode_q) && $stable(addr_hi_q))
		else $error("strapped mode changed without reset");
	chk_sdo_twi: assert property (
		twi_on |-> !spi_data_out_pin_oe_o)
		else $error("data-out pin driven in two-wire mode");
	chk_sda_spi: assert property (
		spi_on |-> !host_data_in_io_oe_o)
		else $error("data-in pin driven in SPI mode");
	chk_twi_other: assert property (
		(twi_st_q == TWI_ADDR && fall && twi_cnt_q == 4'h8 && !start && !stop
			&& twi_sh_q[7:1] != my_addr) |=> (twi_st_q == TWI_IDLE && !twi_drv_q))
		else $error("answered a foreign two-wire address");
	chk_twi_ack: assert property (
		$rose(twi_st_q == TWI_ACK_A) |-> (twi_sh_q[7:1] == my_addr && twi_drv_q))
		else $error("address acknowledged without match");

	cov_twi_read:  cover property (twi_pop);
	cov_twi_write: cover property (twi_wr_evt && !status_q);
	cov_spi_cmd:   cover property (spi_evt && !status_q);
	cov_spi_read:  cover property (spi_evt && status_q);

endmodule

`default_nettype wire

// ==== test/hpc_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none

module hpc_host_model (
	// host driven pins
	output logic      sck_o,
	output logic      ss_n_o,
	output logic      pull_lo_o,
	// device driven pins
	input  wire logic miso_i,
	input  wire logic sda_i
);
	localparam time TS = 3;
	localparam time TW = 100;

	// ----------------------------------------------------------------
	// idle levels
	// ----------------------------------------------------------------
	initial begin
		sck_o     = 1'b0;
		// low until the first reset, whose rise clears the shift logic
		ss_n_o    = 1'b0;
		pull_lo_o = 1'b0;
	end

	task automatic set_idle(input logic twi);
		sck_o     = twi; // clock stands still between frames
		ss_n_o    = ~twi;
		pull_lo_o = 1'b0;
	endtask

	// ----------------------------------------------------------------
	// spi mode 0 and two-wire master
	// ----------------------------------------------------------------
	task automatic spi_xfer(input logic [7:0] tx, output logic [7:0] rx);
		ss_n_o = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			pull_lo_o = ~tx[i]; // data moves while clock low
			#TS sck_o = 1'b1; // host makes the serial clock
			rx[i] = miso_i; // sample on rising edge
			#TS sck_o = 1'b0;
		end
		#TS ss_n_o = 1'b1;
		pull_lo_o = ~pull_lo_o;
		#100;
	endtask

	task automatic twi_start();
		#TW pull_lo_o = 1'b1;
		#TW sck_o = 1'b0;
	endtask

	task automatic twi_bit(input logic b, output logic r);
		#20 pull_lo_o = ~b;
		#TW sck_o = 1'b1; // host makes the serial clock
		#TW r = sda_i;
		sck_o = 1'b0;
	endtask

	task automatic twi_byte(input logic [7:0] tx, input logic last,
			output logic [7:0] rx, output logic ack);
		for (int i = 7; i >= 0; i--) twi_bit(tx[i], rx[i]);
		twi_bit(last, ack);
	endtask

	task automatic twi_stop();
		#20 pull_lo_o = 1'b1;
		#TW sck_o = 1'b1;
		#TW pull_lo_o = 1'b0;
		#TW;
	endtask
endmodule

`default_nettype wire

// ==== test/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none

module tb_top
	import hpc_pkg::*;
;
	logic       clk_i = 1'b0;
	logic       sys_rst_i = 1'b1;
	logic       device_reset_n_i = 1'b1;
	logic       interface_select_strap_i = 1'b1;
	logic       address_strap_i = 1'b0;
	logic       clk_cfg_wr_i = 1'b0;
	logic [7:0] clk_cfg_data_i = 8'h00;
	logic [7:0] resp_data_i = 8'h00;
	logic       resp_valid_i = 1'b0;
	wire logic  host_sck;
	wire logic  ss_n;
	wire logic  pull_lo;
	wire logic  sda_oe;
	wire logic  sda_o;
	wire logic  miso;
	wire logic  miso_oe;
	wire logic  host_status_o;
	wire logic  aux_clock_output_o;
	wire logic  aux_clock_output_oe_o;
	wire logic  spi_mode_o;
	wire logic  resp_ready_o;
	wire logic  cmd_valid_o;
	wire logic [7:0] clk_cfg_o;
	wire logic [7:0] cmd_data_o;
	wire logic  sda_pin = (sda_oe ? sda_o : 1'b1) & ~pull_lo;
	logic [4:0] halves [4] = '{AUX_CLOCK_OUTPUT_HALF_0, AUX_CLOCK_OUTPUT_HALF_1, AUX_CLOCK_OUTPUT_HALF_2, AUX_CLOCK_OUTPUT_HALF_3};
	logic [7:0] exp_cmd [$];
	logic [7:0] tx_q;
	integer     seed;
	int         n_errors = 0;
	int         tests_run = 0;

	always #5 clk_i = ~clk_i;

	hpc_host_model i_host (.sck_o(host_sck), .ss_n_o(ss_n), .pull_lo_o(pull_lo),
		.miso_i(miso), .sda_i(sda_pin));

	hpc_host_port i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .host_sck_i(host_sck),
		.device_reset_n_i(device_reset_n_i),
		.interface_select_strap_i(interface_select_strap_i),
		.address_strap_i(address_strap_i), .spi_select_n_i(ss_n),
		.host_data_in_io_i(sda_pin), .host_data_in_io_o(sda_o),
		.host_data_in_io_oe_o(sda_oe), .spi_data_out_pin_o(miso),
		.spi_data_out_pin_oe_o(miso_oe), .host_status_o(host_status_o),
		.aux_clock_output_o(aux_clock_output_o),
		.aux_clock_output_oe_o(aux_clock_output_oe_o), .clk_cfg_wr_i(clk_cfg_wr_i),
		.clk_cfg_data_i(clk_cfg_data_i), .clk_cfg_o(clk_cfg_o), .spi_mode_o(spi_mode_o),
		.resp_data_i(resp_data_i), .resp_valid_i(resp_valid_i),
		.resp_ready_o(resp_ready_o), .cmd_data_o(cmd_data_o), .cmd_valid_o(cmd_valid_o));

	// ----------------------------------------------------------------
	// compare and drive helpers
	// ----------------------------------------------------------------
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string s);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %0t %s got %h exp %h", $time, s, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp, input string s);
		chk8({7'h00, got}, {7'h00, exp}, s);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	task automatic do_reset(input logic sel, input logic adr);
		tick(1);
		device_reset_n_i = 1'b0;
		interface_select_strap_i = sel;
		address_strap_i = adr;
		i_host.set_idle(~sel);
		sys_rst_i = 1'b1;
		tx_q = 8'hFF;
		tick(1);
		device_reset_n_i = 1'b1;
		tick(8);
		sys_rst_i = 1'b0;
		tick(2);
		chk1(spi_mode_o, sel, "mode");
	endtask

	task automatic give_resp(input logic [7:0] d);
		resp_data_i = d;
		resp_valid_i = 1'b1;
		for (int i = 0; i < 50 && resp_ready_o !== 1'b1; i++) tick(1);
		tick(1);
		resp_valid_i = 1'b0;
		tx_q = d;
		tick(1);
		chk1(host_status_o, 1'b1, "status set");
		chk1(resp_ready_o, 1'b0, "ready low");
	endtask

	task automatic cfg_write(input logic [7:0] d);
		clk_cfg_data_i = d;
		clk_cfg_wr_i = 1'b1;
		tick(1);
		clk_cfg_wr_i = 1'b0;
		tick(2);
		chk8(clk_cfg_o, d, "cfg");
		chk1(aux_clock_output_oe_o, ~d[CFG_DISABLE_BIT], "clk en");
	endtask

	task automatic meas_rate(input logic [1:0] r);
		logic p;
		int   n;
		n = 0;
		for (int j = 0; j < 2; j++) begin
			p = aux_clock_output_o;
			for (int i = 0; i < 60 && aux_clock_output_o === p; i++) tick(1);
		end
		p = aux_clock_output_o;
		while (n < 60 && aux_clock_output_o === p) begin
			n++;
			tick(1);
		end
		chk8(8'(n), {3'b000, halves[r]}, "half period");
	endtask

	task automatic spi_cmd(input logic [7:0] d);
		logic [7:0] rx;
		if (host_status_o === 1'b0) exp_cmd.push_back(d);
		i_host.spi_xfer(d, rx);
		tick(15);
		chk8(rx, tx_q, "sdo byte");
		chk1(host_status_o, 1'b0, "status clear");
	endtask

	task automatic twi_xfer(input logic [7:0] a, input logic [7:0] d, input logic ack);
		logic [7:0] r;
		logic       k;
		i_host.twi_start();
		i_host.twi_byte(a, 1'b1, r, k);
		chk1(k, ~ack, "addr ack");
		if (ack && a[0]) begin
			i_host.twi_byte(8'hFF, 1'b1, r, k);
			chk8(r, tx_q, "read byte");
		end else if (ack) begin
			exp_cmd.push_back(d);
			i_host.twi_byte(d, 1'b1, r, k);
			chk1(k, 1'b0, "data ack");
		end
		i_host.twi_stop();
		tick(10);
		chk1(host_status_o, 1'b0, "status clear");
	endtask

	// ----------------------------------------------------------------
	// reference checks at every result
	// ----------------------------------------------------------------
	always @(posedge clk_i) begin
		if (cmd_valid_o === 1'b1) begin
			if (exp_cmd.size() == 0) chk1(1'b1, 1'b0, "stray cmd");
			else chk8(cmd_data_o, exp_cmd.pop_front(), "cmd byte");
		end
		if (!sys_rst_i && spi_mode_o === INTF_TWI) chk1(miso_oe, 1'b0, "sdo en");
		if (!sys_rst_i && spi_mode_o === INTF_SPI) chk1(sda_oe, 1'b0, "sdi en");
	end

	initial begin
		#500000;
		n_errors++;
		$display("MISMATCH %0t watchdog expired", $time);
		print_verdict();
	end

	initial begin
		seed = 32'h9394;
		do_reset(INTF_SPI, 1'b0);
		chk8(clk_cfg_o, CFG_RESET, "cfg reset");
		chk1(aux_clock_output_oe_o, 1'b1, "clk en reset");
		meas_rate(2'b00);
		for (int r = 3; r >= 0; r--) begin
			cfg_write(8'hC0 | 8'(r));
			meas_rate(2'(r));
		end
		cfg_write(8'h23);
		$display("test clock_out done");
		repeat (4) spi_cmd(8'($random(seed)));
		give_resp(8'($random(seed)));
		spi_cmd(8'h3C);
		interface_select_strap_i = 1'b0;
		tick(10);
		chk1(spi_mode_o, 1'b1, "mode held");
		interface_select_strap_i = 1'b1;
		give_resp(8'($random(seed)));
		device_reset_n_i = 1'b0;
		tick(8);
		chk1(host_status_o, 1'b0, "status reset");
		chk8(clk_cfg_o, CFG_RESET, "cfg reset");
		device_reset_n_i = 1'b1;
		tx_q = 8'hFF;
		tick(8);
		spi_cmd(8'($random(seed)));
		$display("test spi done");
		do_reset(INTF_TWI, 1'b0);
		twi_xfer(8'h50, 8'($random(seed)), 1'b1);
		twi_xfer(8'hD4, 8'h00, 1'b0);
		give_resp(8'($random(seed)));
		twi_xfer(8'h51, 8'h00, 1'b1);
		do_reset(INTF_TWI, 1'b1);
		twi_xfer(8'hD4, 8'($random(seed)), 1'b1);
		twi_xfer(8'h50, 8'h00, 1'b0);
		twi_xfer(8'h52, 8'h00, 1'b0);
		give_resp(8'($random(seed)));
		twi_xfer(8'hD5, 8'h00, 1'b1);
		$display("test two_wire done");
		chk8(8'(exp_cmd.size()), 8'h00, "cmd missing");
		print_verdict();
	end
endmodule

`default_nettype wire
